// file: rtl/serializer_feeder.sv
// Purpose: Fabric end: makes the divided clock, reset pulse and words
// Assumes: Software reaches its registers over AXI4-Lite
// Notes:   One write and one read outstanding at most
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "output_serializer_consts.svh"

module serializer_feeder #(
    parameter int RATIO = 2
) (
    // Clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // AXI4-Lite slave
    input  wire logic [`OSER_AXI_ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [`OSER_AXI_ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Serializer side
    parallel_side_if.fabric                    par
);

    localparam logic [`OSER_CNT_W-1:0] LAST = `OSER_CNT_W'(RATIO - 1);
    localparam logic [`OSER_CNT_W-1:0] HALF = `OSER_CNT_W'((RATIO + 1) / 2);

    output_serializer_pkg::reset_state_e rst_state_reg;
    logic [`OSER_CNT_W-1:0]      div_cnt_reg;
    logic [`OSER_CNT_W-1:0]      div_cnt_next;
    logic                        div_reg;
    logic                        rise_next;
    logic [1:0]                  ctrl_reg;
    logic [`OSER_DATA_W-1:0]     data_reg;
    logic [`OSER_TRI_W-1:0]      tri_reg;
    logic                        pend_reg;
    logic                        rst_out_reg;
    logic                        aw_full_reg;
    logic                        w_full_reg;
    logic [`OSER_AXI_ADDR_W-1:0] aw_addr_reg;
    logic [31:0]                 w_data_reg;
    logic [3:0]                  w_strb_reg;
    logic                        do_write;
    logic                        rst_req;

    ////////////////////////////////////////////////////////////////////////////////
    // Divided clock, phase aligned to aclk

    assign div_cnt_next = (div_cnt_reg == LAST) ? '0 : div_cnt_reg + `OSER_CNT_W'(1);
    assign rise_next    = (div_cnt_next == '0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_reg <= LAST;
            div_reg     <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            div_reg     <= (div_cnt_next < HALF);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset pulse: starts and ends on a divided rise, one period long

    assign rst_req = do_write && (aw_addr_reg == `OSER_CTRL_OFS) && w_strb_reg[0]
                     && w_data_reg[`OSER_CTRL_RST_BIT];

    // New request wins over the clear on arming
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend_reg <= 1'b1;
        end else if (rst_req) begin
            pend_reg <= 1'b1;
        end else if (rst_state_reg == output_serializer_pkg::RST_IDLE) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_state_reg <= output_serializer_pkg::RST_IDLE;
            rst_out_reg   <= 1'b0;
        end else begin
            case (rst_state_reg)
                output_serializer_pkg::RST_IDLE: begin
                    if (pend_reg) begin
                        rst_state_reg <= output_serializer_pkg::RST_ARM;
                    end
                end
                output_serializer_pkg::RST_ARM: begin
                    if (rise_next) begin
                        rst_out_reg   <= 1'b1;
                        rst_state_reg <= output_serializer_pkg::RST_HOLD;
                    end
                end
                output_serializer_pkg::RST_HOLD: begin
                    if (rise_next) begin
                        rst_out_reg   <= 1'b0;
                        rst_state_reg <= output_serializer_pkg::RST_IDLE;
                    end
                end
                default: begin
                    rst_state_reg <= output_serializer_pkg::RST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            aw_addr_reg  <= '0;
            w_data_reg   <= '0;
            w_strb_reg   <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `OSER_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == `OSER_CTRL_OFS || aw_addr_reg == `OSER_DATA_OFS
                    || aw_addr_reg == `OSER_TRI_OFS) begin
                    s_axi_bresp <= `OSER_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `OSER_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `OSER_CTRL_RESET;
            data_reg <= `OSER_DATA_RESET;
            tri_reg  <= `OSER_TRI_RESET;
        end else if (do_write && w_strb_reg[0]) begin
            if (aw_addr_reg == `OSER_CTRL_OFS) begin
                ctrl_reg <= w_data_reg[1:0];
            end else if (aw_addr_reg == `OSER_DATA_OFS) begin
                data_reg <= w_data_reg[`OSER_DATA_W-1:0];
            end else if (aw_addr_reg == `OSER_TRI_OFS) begin
                tri_reg <= w_data_reg[`OSER_TRI_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `OSER_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `OSER_RESP_OKAY;
            if (s_axi_araddr == `OSER_CTRL_OFS) begin
                s_axi_rdata <= {30'h0, ctrl_reg};
            end else if (s_axi_araddr == `OSER_DATA_OFS) begin
                s_axi_rdata <= {26'h0, data_reg};
            end else if (s_axi_araddr == `OSER_TRI_OFS) begin
                s_axi_rdata <= {28'h0, tri_reg};
            end else if (s_axi_araddr == `OSER_STATUS_OFS) begin
                s_axi_rdata <= {30'h0, div_reg,
                                pend_reg || (rst_state_reg != output_serializer_pkg::RST_IDLE)};
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= `OSER_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel side drive

    assign par.divided_parallel_clock = div_reg;
    assign par.async_reset_in         = rst_out_reg;
    assign par.parallel_data_in       = data_reg;
    assign par.parallel_tristate_in   = tri_reg;
    assign par.data_path_clock_enable = ctrl_reg[`OSER_CTRL_DCE_BIT];
    assign par.tristate_clock_enable  = ctrl_reg[`OSER_CTRL_TCE_BIT];

endmodule

// file: rtl/output_serializer_consts.svh
// Purpose: Shared constants for the output serializer and its feeder
// Assumes: Included by bare name
// Notes:   Offsets are byte addresses on the feeder's register bus
`ifndef OUTPUT_SERIALIZER_CONSTS_SVH
`define OUTPUT_SERIALIZER_CONSTS_SVH

`define OSER_DATA_W       6
`define OSER_TRI_W        4
`define OSER_CNT_W        3
`define OSER_SLAVE_LSB    2
`define OSER_AXI_ADDR_W   4

`define OSER_CTRL_OFS     4'h0
`define OSER_DATA_OFS     4'h4
`define OSER_TRI_OFS      4'h8
`define OSER_STATUS_OFS   4'hc

`define OSER_CTRL_DCE_BIT 0
`define OSER_CTRL_TCE_BIT 1
`define OSER_CTRL_RST_BIT 2
`define OSER_STAT_BSY_BIT 0
`define OSER_STAT_DIV_BIT 1

`define OSER_CTRL_RESET   2'h0
`define OSER_DATA_RESET   6'h00
`define OSER_TRI_RESET    4'h0

`define OSER_RESP_OKAY    2'h0
`define OSER_RESP_SLVERR  2'h2

`endif

// file: rtl/output_serializer_pkg.sv
// Purpose: Types shared by the serializer, its feeder and their testbench
// Assumes: Constants come from output_serializer_consts.svh
// Notes:   Types only
package output_serializer_pkg;

    typedef enum logic {
        RATE_SDR = 1'b0,
        RATE_DDR = 1'b1
    } rate_e;

    typedef enum logic {
        ROLE_MASTER = 1'b0,
        ROLE_SLAVE  = 1'b1
    } role_e;

    typedef enum logic [1:0] {
        RST_IDLE = 2'b00,
        RST_ARM  = 2'b01,
        RST_HOLD = 2'b10
    } reset_state_e;

endpackage

// file: rtl/parallel_side_if.sv
// Purpose: Parallel side between fabric feeder and output serializer
// Assumes: One clock; the feeder makes the divided clock from aclk
// Notes:   No clocking block; testbench joins the two ends here
`timescale 1ns/1ps
`include "output_serializer_consts.svh"

interface parallel_side_if;
    logic                       divided_parallel_clock;
    logic [`OSER_DATA_W-1:0]    parallel_data_in;
    logic [`OSER_TRI_W-1:0]     parallel_tristate_in;
    logic                       data_path_clock_enable;
    logic                       tristate_clock_enable;
    logic                       async_reset_in;

    modport device (
        input divided_parallel_clock,
        input parallel_data_in,
        input parallel_tristate_in,
        input data_path_clock_enable,
        input tristate_clock_enable,
        input async_reset_in
    );

    modport fabric (
        output divided_parallel_clock,
        output parallel_data_in,
        output parallel_tristate_in,
        output data_path_clock_enable,
        output tristate_clock_enable,
        output async_reset_in
    );
endinterface

// file: rtl/output_serializer.sv
// Purpose: Parallel-to-serial converter for data and tristate control
// Assumes: aclk is the fast serial clock; the divided clock is a level
//          made by same-clock logic, phase aligned to aclk
// Notes:   DDR falls on the low phase of aclk through an output mux
//
// What this block does
// - Data and tristate paths each SDR or DDR
// - Single block takes two to six bits
// - Up to ten bits with slave instance
// - First data input leaves the line first
// - Fabric supplies phase aligned fast, divided clocks
// - Fast clock is N times divided clock
// - Reset before use initialises flow counter
// - Reset pulse synchronous to divided clock
// - Tristate word at most four bits
// - Tristate path has no cascade
// - Tristate word of one, two, four bits
// - Data enable high; low holds data path
// - Tristate enable high; low holds tristate path
// - Reset clears every data flop immediately
// - Reset retimed into fast and divided domains
// - Reset held high one divided cycle
// - Lanes sharing reset leave it together
// - Slave cascade outputs feed master inputs
// - Inverse preset pin is ignored
// - Serial tristate drives buffer enable
// - Slave uses only third to sixth inputs
`timescale 1ns/1ps
`include "output_serializer_consts.svh"

module output_serializer #(
    parameter output_serializer_pkg::rate_e DATA_RATE      = output_serializer_pkg::RATE_DDR,
    parameter output_serializer_pkg::rate_e TRISTATE_RATE  = output_serializer_pkg::RATE_DDR,
    parameter output_serializer_pkg::role_e SERDES_ROLE    = output_serializer_pkg::ROLE_MASTER,
    parameter int                           DATA_WIDTH     = 4,
    parameter int                           TRISTATE_WIDTH = 4
) (
    // Clock and bus reset
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // Fabric side
    parallel_side_if.device     par,
    // Cascade between master and slave
    input  wire logic           cascade_in_a,
    input  wire logic           cascade_in_b,
    output logic                cascade_out_a,
    output logic                cascade_out_b,
    // Unused preset pin
    input  wire logic           inverse_preset_pin,
    // Buffer side
    output logic                serial_data_out,
    output logic                serial_tristate_out
);

    localparam int D_STEP = (DATA_RATE == output_serializer_pkg::RATE_DDR) ? 2 : 1;
    localparam int T_STEP = (TRISTATE_RATE == output_serializer_pkg::RATE_DDR) ? 2 : 1;
    localparam int N_CYC  = DATA_WIDTH / D_STEP;
    localparam logic [`OSER_CNT_W-1:0] LAST = `OSER_CNT_W'(N_CYC - 1);
    localparam bit D_DDR = (DATA_RATE == output_serializer_pkg::RATE_DDR);
    localparam bit T_DDR = (TRISTATE_RATE == output_serializer_pkg::RATE_DDR);

    logic                       rst_meta_reg;
    logic                       rst_sync_reg;
    logic                       run_reg;
    logic                       div_prev_reg;
    logic                       div_rise;
    logic                       reload;
    logic [`OSER_CNT_W-1:0]     cnt_reg;
    logic [`OSER_DATA_W-1:0]    word_reg;
    logic [`OSER_DATA_W-1:0]    sreg_reg;
    logic [`OSER_DATA_W-1:0]    sreg_next;
    logic [`OSER_TRI_W-1:0]     t_word_reg;
    logic [`OSER_TRI_W-1:0]     t_sreg_reg;
    logic [`OSER_TRI_W-1:0]     t_sreg_next;
    logic                       d_rise_reg;
    logic                       d_fall_reg;
    logic                       t_rise_reg;
    logic                       t_fall_reg;
    logic                       preset_unused;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset retiming

    // Preset has no function here
    assign preset_unused = inverse_preset_pin;

    // Fast-domain retime: assertion immediate, release after two edges
    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else begin
            rst_meta_reg <= ~aresetn;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Divided clock comes from same-clock logic, no synchroniser needed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_prev_reg <= 1'b0;
        end else begin
            div_prev_reg <= par.divided_parallel_clock;
        end
    end

    assign div_rise = par.divided_parallel_clock & ~div_prev_reg;

    // Divided-domain retime: run starts only on a divided rise, so every
    // lane fed by the same pulse starts its counter on the same edge
    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            run_reg <= 1'b0;
        end else if (rst_sync_reg) begin
            run_reg <= 1'b0;
        end else if (div_rise) begin
            run_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flow counter

    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            cnt_reg <= '0;
        end else if (!run_reg) begin
            cnt_reg <= '0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + `OSER_CNT_W'(1);
        end
    end

    assign reload = run_reg && (cnt_reg == LAST);

    ////////////////////////////////////////////////////////////////////////////////
    // Parallel capture

    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            word_reg <= '0;
        end else if (!run_reg) begin
            word_reg <= '0;
        end else if (div_rise && par.data_path_clock_enable) begin
            if (SERDES_ROLE == output_serializer_pkg::ROLE_SLAVE) begin
                // Slave bits sit low so they shift out in D3..D6 order
                word_reg <= {2'h0, par.parallel_data_in[`OSER_DATA_W-1:`OSER_SLAVE_LSB]};
            end else begin
                word_reg <= par.parallel_data_in;
            end
        end
    end

    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            t_word_reg <= '0;
        end else if (!run_reg) begin
            t_word_reg <= '0;
        end else if (div_rise && par.tristate_clock_enable) begin
            case (TRISTATE_WIDTH)
                1:       t_word_reg <= {4{par.parallel_tristate_in[0]}};
                2:       t_word_reg <= {{3{par.parallel_tristate_in[1]}},
                                        par.parallel_tristate_in[0]};
                default: t_word_reg <= par.parallel_tristate_in;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift paths

    // Master refills its top from the slave; lowest bit always leaves first
    always_comb begin
        if (reload) begin
            sreg_next = word_reg;
        end else if (D_STEP == 2) begin
            sreg_next = {cascade_in_b, cascade_in_a, sreg_reg[`OSER_DATA_W-1:2]};
        end else begin
            sreg_next = {cascade_in_a, sreg_reg[`OSER_DATA_W-1:1]};
        end
    end

    // Tristate shift refills with its own top bit: no cascade path
    always_comb begin
        if (reload) begin
            t_sreg_next = t_word_reg;
        end else if (T_STEP == 2) begin
            t_sreg_next = {{2{t_sreg_reg[3]}}, t_sreg_reg[3:2]};
        end else begin
            t_sreg_next = {t_sreg_reg[3], t_sreg_reg[3:1]};
        end
    end

    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            sreg_reg   <= '0;
            t_sreg_reg <= '0;
        end else if (!run_reg) begin
            sreg_reg   <= '0;
            t_sreg_reg <= '0;
        end else begin
            sreg_reg   <= sreg_next;
            t_sreg_reg <= t_sreg_next;
        end
    end

    // Slave hands its two lowest bits to the master each fast edge
    assign cascade_out_a = sreg_reg[0];
    assign cascade_out_b = sreg_reg[1];

    ////////////////////////////////////////////////////////////////////////////////
    // Output stage

    // Enable gates the output flops and word capture, not the counter or shift, so the counter never drifts
    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            d_rise_reg <= 1'b0;
            d_fall_reg <= 1'b0;
        end else if (!run_reg) begin
            d_rise_reg <= 1'b0;
            d_fall_reg <= 1'b0;
        end else if (par.data_path_clock_enable) begin
            d_rise_reg <= sreg_next[0];
            d_fall_reg <= sreg_next[1];
        end
    end

    always_ff @(posedge aclk or posedge par.async_reset_in) begin
        if (par.async_reset_in) begin
            t_rise_reg <= 1'b0;
            t_fall_reg <= 1'b0;
        end else if (!run_reg) begin
            t_rise_reg <= 1'b0;
            t_fall_reg <= 1'b0;
        end else if (par.tristate_clock_enable) begin
            t_rise_reg <= t_sreg_next[0];
            t_fall_reg <= t_sreg_next[1];
        end
    end

    // Mux on the clock level: limitation is a clock-to-data path on the pin
    assign serial_data_out     = (D_DDR && !aclk) ? d_fall_reg : d_rise_reg;
    assign serial_tristate_out = (T_DDR && !aclk) ? t_fall_reg : t_rise_reg;

endmodule

// file: tb/output_serializer_properties.sv
// Purpose: Timing checks on the parallel side and the serial outputs
// Assumes: SDR outputs, so a low enable freezes the output flops
// Notes:   One clock; the divided clock is a level made from aclk
`timescale 1ns/1ps
module output_serializer_checker #(
    parameter int RATIO = 4
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic divided_parallel_clock,
    input  wire logic data_path_clock_enable,
    input  wire logic tristate_clock_enable,
    input  wire logic async_reset_in,
    input  wire logic serial_data_out,
    input  wire logic serial_tristate_out
);
    wire dv = divided_parallel_clock, rs = async_reset_in;
    wire dq = serial_data_out, tq = serial_tristate_out;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////
    property p_div_period; $rose(dv) |-> ##RATIO $rose(dv); endproperty
    a_div_period: assert property (p_div_period) else $error("divided period wrong");
    property p_rst_aligned; $rose(rs) |-> $rose(dv); endproperty
    a_rst_aligned: assert property (p_rst_aligned) else $error("reset off divided rise");
    property p_rst_len; $rose(rs) |-> ##RATIO $fell(rs); endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
    property p_boot_rst; $rose(aresetn) |-> ##[1:16] rs; endproperty
    a_boot_rst: assert property (p_boot_rst) else $error("no reset pulse after boot");
    property p_clear; rs |-> !dq && !tq; endproperty
    a_clear: assert property (p_clear) else $error("outputs not cleared in reset");
    property p_release; $fell(rs) |-> (!dq && !tq)[*4]; endproperty
    a_release: assert property (p_release) else $error("outputs early after reset");
    property p_hold_d; !data_path_clock_enable && !rs |=> rs || $stable(dq); endproperty
    a_hold_d: assert property (p_hold_d) else $error("data moved while disabled");
    property p_hold_t; !tristate_clock_enable && !rs |=> rs || $stable(tq); endproperty
    a_hold_t: assert property (p_hold_t) else $error("tristate moved while disabled");
endmodule

// file: tb/output_parallel_to_serial_converter_tb_top.sv
// Purpose: Feeder and serializer end to end, driven over AXI4-Lite
// Assumes: SDR, width 4, ratio 4, tristate width 1
// Notes:   Queue model holds the bits each word must send
`timescale 1ns/1ps
`include "output_serializer_consts.svh"

module output_parallel_to_serial_converter_tb_top;
    logic        aclk, aresetn, pre, ca, cb, awv, wv, bready, arv, rready, p;
    logic        awready, wready, bvalid, arready, rvalid, sdo, sto;
    logic [3:0]  awaddr, araddr, ws = 4'hf;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r;
    int          num_errors, tests_run, cyc, te, q[$];
    parallel_side_if par_if();
    serializer_feeder #(.RATIO(4)) serializer_feeder_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .par(par_if));
    output_serializer #(.DATA_RATE(output_serializer_pkg::RATE_SDR),
        .TRISTATE_RATE(output_serializer_pkg::RATE_SDR), .TRISTATE_WIDTH(1))
        output_serializer_inst (
        .aclk(aclk), .aresetn(aresetn), .par(par_if), .cascade_in_a(ca),
        .cascade_in_b(cb), .cascade_out_a(), .cascade_out_b(), .inverse_preset_pin(pre),
        .serial_data_out(sdo), .serial_tristate_out(sto));
    output_serializer_checker #(.RATIO(4)) output_serializer_checker_inst (
        .aclk(aclk), .aresetn(aresetn), .divided_parallel_clock(par_if.divided_parallel_clock),
        .data_path_clock_enable(par_if.data_path_clock_enable),
        .tristate_clock_enable(par_if.tristate_clock_enable),
        .async_reset_in(par_if.async_reset_in), .serial_data_out(sdo), .serial_tristate_out(sto));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Ready is peeked at the falling edge, then taken at the next rise
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        while (awv || wv) begin
            @(negedge aclk);
            ta = awv && awready; tw = wv && wready;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end
        do @(negedge aclk); while (!bvalid);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arv <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        v = rdata; r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    task automatic send(input logic [31:0] d);
        wr(`OSER_CTRL_OFS, 32'h3); wr(`OSER_TRI_OFS, d >> 8); wr(`OSER_DATA_OFS, d);
        q = {d[0], d[1], d[2], d[3]}; te = d[8];
        repeat (12) @(posedge aclk);
    endtask
    // Word repeats each period, so any divided rise starts a fresh word
    task automatic grab();
        do begin p = par_if.divided_parallel_clock; @(negedge aclk); end
        while (!(par_if.divided_parallel_clock && !p));
        foreach (q[i]) begin
            @(negedge aclk);
            chk("serial data", q[i], sdo);
            chk("serial tristate", te, sto);
        end
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        {pre, ca, cb} <= 3'($urandom);
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        {aresetn, pre, ca, cb, awv, wv, bready, arv, rready, awaddr, araddr, wdata} = '0;
        void'($urandom(46112));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 12; a += 4) begin
            rd(4'(a));
            chk("reset value", 32'h0, v);
            chk("read resp", `OSER_RESP_OKAY, r);
        end
        rd(4'h6);
        chk("unmapped resp", `OSER_RESP_SLVERR, r);
        wr(4'h6, 32'h1);
        chk("unmapped write resp", `OSER_RESP_SLVERR, r);
        ws <= 4'h0;
        wr(`OSER_DATA_OFS, 32'h3f);
        ws <= 4'hf;
        rd(`OSER_DATA_OFS);
        chk("masked write", 32'h0, v);
        $display("register test done");
        for (int k = 0; k < 8; k++) begin
            send($urandom);
            rd(`OSER_DATA_OFS);
            chk("data readback", 32'(wdata[5:0]), v);
            grab();
        end
        $display("stream test done");
        wr(`OSER_CTRL_OFS, 32'h0);
        wr(`OSER_DATA_OFS, ~wdata);
        @(negedge aclk);
        p = sdo; v[0] = sto;
        repeat (8) begin
            @(negedge aclk);
            chk("held data", p, sdo);
            chk("held tristate", v[0], sto);
        end
        $display("enable test done");
        wr(`OSER_CTRL_OFS, 32'h5);
        rd(`OSER_STATUS_OFS);
        chk("reset busy", 32'h1, 32'(v[0]));
        do @(negedge aclk); while (!par_if.async_reset_in);
        chk("data in reset", 1'b0, sdo);
        chk("tristate in reset", 1'b0, sto);
        send($urandom);
        grab();
        $display("reset test done");
        close_out();
    end
endmodule
